// >>> hdl/bmc_pkg.sv
// Package with the register map, field layout and reset values of the bus map block.
package bmc_pkg;

	// ==========================================================
	// Register addresses on the local processor I/O page
	localparam logic [31:0] ADDR_SYS_CONFIG = 32'h1008_0000;
	localparam logic [31:0] ADDR_DMA_ERROR_STATUS = 32'h1008_0004;
	localparam logic [31:0] ADDR_MAP_BASE = 32'h1008_0010;

	// ==========================================================
	// Field positions and masks
	localparam int POS_POWER_GOOD = 15;
	localparam int POS_HALT_ENABLE = 14;
	localparam int POS_DC_LOSS_SELECT = 7;
	localparam int POS_HALT_DETECTED = 15;
	localparam int POS_DC_LOSS_DETECTED = 14;
	localparam logic [31:0] MASK_MAP_BASE = 32'h1FFF_8000;
	localparam logic [31:0] MASK_STATUS = 32'h0000_C000;
	localparam logic [3:0] BE_FULL_WORD = 4'hF;

	// ==========================================================
	// Reset values, read-zero value and synchroniser width
	localparam logic [31:0] RESET_MAP_BASE = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	localparam int SYNC_WIDTH = 3;

endpackage : bmc_pkg

// >>> hdl/bmc_sync.sv
// Two flip-flop synchroniser for the backplane input lines.
`timescale 1ns/10ps
`default_nettype none

module bmc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ==========================================================
	// Synchroniser stages
	logic [WIDTH-1:0] stage_one;

	// The first stage feeds only the second stage, to keep metastability contained.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule // bmc_sync

`default_nettype wire

// >>> hdl/bmc_top.sv
// Bus map base register, system configuration register and backplane event logic.
//
// How it works
// RL1 - Map table is 8K words, 32 Kbyte, base aligned on a 32 Kbyte boundary.
// RL2 - Firmware loads map base with the top good 32 Kbyte memory block.
// RL3 - Software protects the map and reaches entries only via the I/O window.
// RL4 - Map base register holds the map location, decoded at its fixed address.
// RL5 - Map base is read/write, full aligned word accesses only.
// RL6 - Map base bits 31:29 and 14:0 read zero; software writes zero.
// RL7 - Any map base write flushes the whole cached map.
// RL8 - Map base is unaffected by backplane initialize; otherwise undefined after loss.
// RL9 - Configuration register decodes at its address with word, half and byte access.
// RL10 - Configuration option bits clear on power-up and DC-good loss while halted.
// RL11 - Unused configuration bits read zero; software writes zero.
// RL12 - Configuration bit 15 mirrors backplane power good and ignores writes.
// RL13 - With halt enable set, backplane halt halts processor and sets status bit 15.
// RL14 - DC-good loss with select clear asserts the board system reset.
// RL15 - DC-good loss with select set asserts the processor halt input.
// RL16 - Error status bits set on events and clear by writing one, on reset or on DC-good loss while halted.
// RL17 - Reserved configuration bits 10 and 3:1 read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none

module bmc_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cpu_req,
	input wire logic cpu_write,
	input wire logic [31:0] cpu_addr,
	input wire logic [3:0] cpu_byte_enable,
	input wire logic [31:0] cpu_wdata,
	output logic cpu_ack,
	output logic cpu_error,
	output logic [31:0] cpu_rdata,
	input wire logic processor_halted,
	input wire logic backplane_halt_line,
	input wire logic backplane_power_good_line,
	input wire logic backplane_dc_good_line,
	input wire logic backplane_initialize_line,
	output logic [31:0] map_table_base,
	output logic map_cache_flush,
	output logic board_system_reset,
	output logic processor_halt_input
);
	import bmc_pkg::*;

	// ==========================================================
	// Decode helpers

	// Full-address match, used by both the read and the write paths.
	function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
		addr_hit = (addr == reg_addr);
	endfunction

	// Expands byte enables into a bit mask for partial writes.
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// ==========================================================
	// Declarations
	logic [SYNC_WIDTH-1:0] pins_raw;
	logic [SYNC_WIDTH-1:0] pins_sync;
	logic halt_sync;
	logic power_good_sync;
	logic dc_good_sync;
	logic dc_good_last;
	logic dc_good_fall;
	logic dc_loss_while_halted;
	logic backplane_halt_enable;
	logic dc_loss_response_select;
	logic halt_detected;
	logic dc_loss_detected;
	logic [31:0] bus_map_base_address;
	logic [31:0] system_configuration;
	logic [31:0] dma_error_status;
	logic [31:0] write_mask;
	logic hit_config;
	logic hit_status;
	logic hit_map;
	logic write_config;
	logic write_status;
	logic write_map;
	logic map_bad_size;
	logic halt_event;

	// ==========================================================
	// Backplane line synchronisation

	// The initialize line is deliberately not used: the map base survives it.
	assign pins_raw = {backplane_dc_good_line, backplane_power_good_line, backplane_halt_line};

	bmc_sync #(
		.WIDTH(SYNC_WIDTH)
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in(pins_raw),
		.sync_out(pins_sync)
	);

	assign halt_sync = pins_sync[0];
	assign power_good_sync = pins_sync[1];
	assign dc_good_sync = pins_sync[2];

	// Remember the DC-good level to find its falling edge.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dc_good_last <= 1'b0;
		end else begin
			dc_good_last <= dc_good_sync;
		end
	end

	// Reset holds the last level low, so no false loss is seen right after reset.
	assign dc_good_fall = dc_good_last & ~dc_good_sync;
	assign dc_loss_while_halted = dc_good_fall & processor_halted;

	// ==========================================================
	// Address decode

	// Map base accepts only aligned full words; anything narrower is refused.
	assign hit_config = addr_hit(cpu_addr, ADDR_SYS_CONFIG);
	assign hit_status = addr_hit(cpu_addr, ADDR_DMA_ERROR_STATUS);
	assign hit_map = addr_hit(cpu_addr, ADDR_MAP_BASE);
	assign map_bad_size = hit_map & (cpu_byte_enable != BE_FULL_WORD); // RL5
	assign write_mask = lane_mask(cpu_byte_enable); // RL9
	assign write_config = cpu_req & cpu_write & hit_config; // RL9
	assign write_status = cpu_req & cpu_write & hit_status;
	assign write_map = cpu_req & cpu_write & hit_map & ~map_bad_size; // RL5

	// ==========================================================
	// Map base register

	// Only bits 28:15 are stored, which keeps the base on a 32 Kbyte boundary.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bus_map_base_address <= RESET_MAP_BASE;
		end else if (write_map) begin
			bus_map_base_address <= cpu_wdata & MASK_MAP_BASE; // RL4 RL6 RL1
		end
	end

	assign map_table_base = bus_map_base_address; // RL8

	// Every accepted write to the map base flushes all cached map entries.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			map_cache_flush <= 1'b0;
		end else begin
			map_cache_flush <= write_map; // RL7
		end
	end

	// ==========================================================
	// Configuration option bits

	// A loss of DC-good while halted wins over a software write in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || dc_loss_while_halted) begin
			backplane_halt_enable <= 1'b0; // RL10
			dc_loss_response_select <= 1'b0; // RL10
		end else if (write_config) begin
			if (write_mask[POS_HALT_ENABLE]) begin
				backplane_halt_enable <= cpu_wdata[POS_HALT_ENABLE];
			end
			if (write_mask[POS_DC_LOSS_SELECT]) begin
				dc_loss_response_select <= cpu_wdata[POS_DC_LOSS_SELECT];
			end
		end
	end

	// Power good mirrors the synchronised line; reserved and unused bits stay zero.
	always_comb begin
		system_configuration = READ_ZERO; // RL11 RL17
		system_configuration[POS_POWER_GOOD] = power_good_sync; // RL12
		system_configuration[POS_HALT_ENABLE] = backplane_halt_enable;
		system_configuration[POS_DC_LOSS_SELECT] = dc_loss_response_select;
	end

	// ==========================================================
	// Backplane events

	assign halt_event = backplane_halt_enable & halt_sync; // RL13

	// Halt input follows the enabled halt line, or pulses on a selected DC-good loss.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			processor_halt_input <= 1'b0;
			board_system_reset <= 1'b0;
		end else begin
			processor_halt_input <= halt_event | (dc_good_fall & dc_loss_response_select); // RL13 RL15
			board_system_reset <= dc_good_fall & ~dc_loss_response_select; // RL14
		end
	end

	// ==========================================================
	// Error status flags

	// Set wins over a write-one clear in the same cycle, so no event is lost.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || dc_loss_while_halted) begin
			halt_detected <= 1'b0;
			dc_loss_detected <= 1'b0;
		end else begin
			if (halt_event) begin
				halt_detected <= 1'b1; // RL13 RL16
			end else if (write_status && write_mask[POS_HALT_DETECTED] &&
					cpu_wdata[POS_HALT_DETECTED]) begin
				halt_detected <= 1'b0; // RL16
			end
			if (dc_good_fall && dc_loss_response_select) begin
				dc_loss_detected <= 1'b1; // RL16
			end else if (write_status && write_mask[POS_DC_LOSS_DETECTED] &&
					cpu_wdata[POS_DC_LOSS_DETECTED]) begin
				dc_loss_detected <= 1'b0; // RL16
			end
		end
	end

	// Only the two backplane flags live here; the other error bits read zero.
	always_comb begin
		dma_error_status = READ_ZERO;
		dma_error_status[POS_HALT_DETECTED] = halt_detected;
		dma_error_status[POS_DC_LOSS_DETECTED] = dc_loss_detected;
	end

	// ==========================================================
	// Processor answer

	// Every request is answered one cycle later; unmapped ones and undersized map base ones flag an error.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cpu_ack <= 1'b0;
			cpu_error <= 1'b0;
			cpu_rdata <= READ_ZERO;
		end else begin
			cpu_ack <= cpu_req;
			cpu_error <= cpu_req & (~(hit_config | hit_status | hit_map) | map_bad_size); // RL5
			if (cpu_req && !cpu_write) begin
				if (hit_config) begin
					cpu_rdata <= system_configuration & write_mask; // RL9
				end else if (hit_status) begin
					cpu_rdata <= dma_error_status & write_mask;
				end else if (hit_map && !map_bad_size) begin
					cpu_rdata <= bus_map_base_address; // RL6
				end else begin
					cpu_rdata <= READ_ZERO;
				end
			end else begin
				cpu_rdata <= READ_ZERO;
			end
		end
	end

endmodule // bmc_top

`default_nettype wire

// >>> verif/bmc_backplane_model.sv
// Behavioural model of the backplane halt, power and initialize lines.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Backplane line driver
module bmc_backplane_model (
	input wire logic clk_sys,
	output logic halt_line,
	output logic pg_line,
	output logic dc_line,
	output logic init_line
);
	// Lines start with DC good high so that no false loss event is seen after reset.
	initial {halt_line, pg_line, dc_line, init_line} = 4'h2;

	// Lines change only at the falling edge, well away from the sampling edge.
	task automatic set(input logic [3:0] v);
		@(negedge clk_sys);
		{halt_line, pg_line, dc_line, init_line} = v;
	endtask
endmodule // bmc_backplane_model

`default_nettype wire

// >>> verif/bmc_properties.sv
// Concurrent checks on the ports of the bus map block.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Port checker
module bmc_properties
	import bmc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cpu_req,
	input wire logic cpu_write,
	input wire logic [31:0] cpu_addr,
	input wire logic [3:0] cpu_byte_enable,
	input wire logic [31:0] cpu_wdata,
	input wire logic cpu_ack,
	input wire logic cpu_error,
	input wire logic [31:0] cpu_rdata,
	input wire logic processor_halted,
	input wire logic backplane_halt_line,
	input wire logic backplane_power_good_line,
	input wire logic backplane_dc_good_line,
	input wire logic backplane_initialize_line,
	input wire logic [31:0] map_table_base,
	input wire logic map_cache_flush,
	input wire logic board_system_reset,
	input wire logic processor_halt_input
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Bus answers, map base update and refusals.
	a_ack_follows: assert property (cpu_req |=> cpu_ack) else $error("ack missing");
	a_flush_on_write: assert property (cpu_req && cpu_write && cpu_addr == ADDR_MAP_BASE
		&& cpu_byte_enable == BE_FULL_WORD |=> map_cache_flush
		&& map_table_base == ($past(cpu_wdata) & MASK_MAP_BASE)) else $error("bad map write");
	a_flush_cause: assert property (map_cache_flush |-> $past(cpu_req && cpu_write
		&& cpu_addr == ADDR_MAP_BASE)) else $error("stray flush");
	a_base_zero_bits: assert property ((map_table_base & ~MASK_MAP_BASE) == READ_ZERO)
		else $error("map base unused bits set");
	a_partial_refused: assert property (cpu_req && cpu_addr == ADDR_MAP_BASE
		&& cpu_byte_enable != BE_FULL_WORD |=> cpu_error && $stable(map_table_base))
		else $error("partial map access taken");
	a_cfg_unused_zero: assert property (cpu_ack && $past(cpu_req && !cpu_write
		&& cpu_addr == ADDR_SYS_CONFIG) |-> (cpu_rdata & 32'hFFFF_3F7F) == READ_ZERO)
		else $error("config unused bits set");
	a_base_holds: assert property (!$past(cpu_req) |-> $stable(map_table_base))
		else $error("map base changed alone");

	// Backplane DC loss responses.
	a_reset_pulse: assert property (board_system_reset |=> !board_system_reset)
		else $error("system reset too long");
	a_dc_response: assert property ($fell(backplane_dc_good_line) |-> ##[3:5]
		(board_system_reset || processor_halt_input)) else $error("no dc loss response");

	cover property (map_cache_flush);
	cover property (board_system_reset);
	cover property (processor_halt_input && backplane_halt_line);
endmodule // bmc_properties

bind bmc_top bmc_properties chk_u (.clk_sys, .sys_rst, .cpu_req, .cpu_write, .cpu_addr,
	.cpu_byte_enable, .cpu_wdata, .cpu_ack, .cpu_error, .cpu_rdata, .processor_halted,
	.backplane_halt_line, .backplane_power_good_line, .backplane_dc_good_line,
	.backplane_initialize_line, .map_table_base, .map_cache_flush, .board_system_reset,
	.processor_halt_input);

`default_nettype wire

// >>> verif/bmc_tb_top.sv
// Self-checking testbench of the bus map block.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Testbench top
module bmc_tb_top;
	import bmc_pkg::*;
	logic clk_sys, sys_rst, cpu_req, cpu_write, processor_halted;
	logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, map_table_base, rd;
	logic [3:0] cpu_byte_enable;
	logic cpu_ack, cpu_error, map_cache_flush, board_system_reset, processor_halt_input;
	logic err, fl, rs, hl;
	logic backplane_halt_line, backplane_power_good_line, backplane_dc_good_line;
	logic backplane_initialize_line;
	int n_mismatch = 0, check_count = 0, cycles = 0;

	// Clock at 50 MHz.
	always #10 clk_sys = ~clk_sys;

	bmc_top dut_u (.clk_sys, .sys_rst, .cpu_req, .cpu_write, .cpu_addr, .cpu_byte_enable,
		.cpu_wdata, .cpu_ack, .cpu_error, .cpu_rdata, .processor_halted, .backplane_halt_line,
		.backplane_power_good_line, .backplane_dc_good_line, .backplane_initialize_line,
		.map_table_base, .map_cache_flush, .board_system_reset, .processor_halt_input);
	bmc_backplane_model bp_u (.clk_sys, .halt_line(backplane_halt_line),
		.pg_line(backplane_power_good_line), .dc_line(backplane_dc_good_line),
		.init_line(backplane_initialize_line));

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One access: request held across one rising edge, answer taken in the next cycle.
	task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clk_sys);
		cpu_req = 1'h1;
		cpu_write = w;
		cpu_addr = a;
		cpu_byte_enable = be;
		cpu_wdata = d;
		@(negedge clk_sys);
		cpu_req = 1'h0;
		rd = cpu_rdata;
		err = cpu_error;
		fl = map_cache_flush;
		check("ack", {31'h0, cpu_ack}, 32'h1);
	endtask

	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		bus(1'h0, a, 4'hF, '0);
		check(nm, rd, exp);
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Pulses last one cycle, so every cycle of the response window is looked at.
	task automatic watch;
		rs = 1'h0;
		hl = 1'h0;
		repeat (8) begin
			@(negedge clk_sys);
			rs = rs | board_system_reset;
			hl = hl | processor_halt_input;
		end
	endtask

	task automatic t_cfg;
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'hFFFF_FFFF);
		rchk("cfg", ADDR_SYS_CONFIG, 32'h0000_4080);
		bp_u.set(4'h6);
		wt(4);
		rchk("cfg pg", ADDR_SYS_CONFIG, 32'h0000_C080);
		bus(1'h1, ADDR_SYS_CONFIG, 4'h1, 32'h0);
		rchk("cfg byte", ADDR_SYS_CONFIG, 32'h0000_C000);
		$display("t_cfg done");
	endtask

	task automatic t_map;
		bus(1'h1, ADDR_MAP_BASE, 4'hF, 32'hFFFF_FFFF);
		check("flush", {31'h0, fl}, 32'h1);
		check("base", map_table_base, 32'h1FFF_8000);
		// Firmware-style load of the top 32 Kbyte block; map entries themselves are never touched.
		bus(1'h1, ADDR_MAP_BASE, 4'hF, 32'h0FFF_8000);
		check("flush again", {31'h0, fl}, 32'h1);
		check("base fw", map_table_base, 32'h0FFF_8000);
		bus(1'h1, ADDR_MAP_BASE, 4'h3, 32'h0);
		check("part err", {31'h0, err}, 32'h1);
		bp_u.set(4'h7);
		wt(4);
		bp_u.set(4'h6);
		rchk("base rd", ADDR_MAP_BASE, 32'h0FFF_8000);
		bus(1'h0, 32'h1008_0020, 4'hF, '0);
		check("unmapped", {31'h0, err}, 32'h1);
		$display("t_map done");
	endtask

	task automatic t_halt;
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'h0);
		bp_u.set(4'hE);
		wt(6);
		check("halt off", {31'h0, processor_halt_input}, 32'h0);
		rchk("st off", ADDR_DMA_ERROR_STATUS, 32'h0);
		bp_u.set(4'h6);
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'h0000_4000);
		bp_u.set(4'hE);
		wt(5);
		check("halt on", {31'h0, processor_halt_input}, 32'h1);
		bp_u.set(4'h6);
		wt(5);
		bus(1'h1, ADDR_DMA_ERROR_STATUS, 4'hF, 32'h0);
		rchk("st keep", ADDR_DMA_ERROR_STATUS, 32'h0000_8000);
		bus(1'h1, ADDR_DMA_ERROR_STATUS, 4'hF, 32'h0000_8000);
		rchk("st clr", ADDR_DMA_ERROR_STATUS, 32'h0);
		$display("t_halt done");
	endtask

	task automatic t_dc;
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'h0000_0080);
		bp_u.set(4'h4);
		watch;
		check("dc halt", {30'h0, rs, hl}, 32'h1);
		rchk("st dc", ADDR_DMA_ERROR_STATUS, 32'h0000_4000);
		bp_u.set(4'h6);
		wt(5);
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'h0);
		bp_u.set(4'h4);
		watch;
		check("dc reset", {30'h0, rs, hl}, 32'h2);
		bp_u.set(4'h6);
		wt(5);
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'h0000_4080);
		processor_halted = 1'h1;
		bp_u.set(4'h4);
		wt(8);
		rchk("cfg clr", ADDR_SYS_CONFIG, 32'h0000_8000);
		check("base kept", map_table_base, 32'h0FFF_8000);
		processor_halted = 1'h0;
		bp_u.set(4'h6);
		wt(5);
		$display("t_dc done");
	endtask

	// A second power-up reset mid-run must clear the options and the status flags.
	task automatic t_rst;
		bus(1'h1, ADDR_SYS_CONFIG, 4'hF, 32'h0000_4080);
		bp_u.set(4'hE);
		wt(4);
		rchk("st pre", ADDR_DMA_ERROR_STATUS, 32'h0000_8000);
		bp_u.set(4'h6);
		sys_rst = 1'h1;
		wt(3);
		sys_rst = 1'h0;
		wt(3);
		rchk("cfg rst", ADDR_SYS_CONFIG, 32'h0000_8000);
		rchk("st rst", ADDR_DMA_ERROR_STATUS, 32'h0);
		$display("t_rst done");
	endtask

	// The whole sequence needs well under a thousand cycles.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			conclude;
		end
	end

	initial begin
		clk_sys = 1'h0;
		sys_rst = 1'h1;
		cpu_req = 1'h0;
		cpu_write = 1'h0;
		processor_halted = 1'h0;
		cpu_addr = 32'h0;
		cpu_wdata = 32'h0;
		cpu_byte_enable = 4'h0;
		repeat (20) @(negedge clk_sys);
		sys_rst = 1'h0;
		t_cfg;
		t_map;
		t_halt;
		t_dc;
		t_rst;
		conclude;
	end
endmodule // bmc_tb_top

`default_nettype wire
